/* lss_pkg.sv */
// Register map, field layout and encodings for the latch source select block
package lss_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    // Register offsets (word index on the plain register port)
    localparam logic [7:0] OFS_LATCH_1_4      = 8'h00;
    localparam logic [7:0] OFS_LATCH_5_8      = 8'h01;
    localparam logic [7:0] OFS_STATION_ADDR   = 8'h02;
    localparam logic [7:0] OFS_TX_BYTES       = 8'h03;
    localparam logic [7:0] OFS_HOME_SPD1_LO   = 8'h04;
    localparam logic [7:0] OFS_HOME_SPD1_HI   = 8'h05;
    localparam logic [7:0] OFS_HOME_SPD2_LO   = 8'h06;
    localparam logic [7:0] OFS_HOME_SPD2_HI   = 8'h07;
    localparam logic [7:0] OFS_HOME_SEL1      = 8'h08;
    localparam logic [7:0] OFS_HOME_SEL2      = 8'h09;
    localparam logic [7:0] OFS_STATUS         = 8'h0A;
    // Reset values
    localparam logic [15:0] RST_LATCH         = 16'h0000;
    localparam logic [15:0] RST_MONITOR       = 16'h0000;
    localparam logic [15:0] RST_HOME          = 16'h0000;
    // Field layout: one 4-bit digit per step, two code bits used
    localparam int unsigned DIGIT_W = 4;
    localparam int unsigned STEPS   = 8;
    // Status register bit positions
    localparam int unsigned STAT_DONE_BIT = 0;
    // Source codes of a digit
    typedef enum logic [1:0] {
        SRC_INDEX = 2'h0,
        SRC_EXT_A = 2'h1,
        SRC_EXT_B = 2'h2,
        SRC_EXT_C = 2'h3
    } lss_src_e;
endpackage

/* lss_src_mux.sv */
// One latch step source multiplexer, registered output
`timescale 1ns/100ps
module lss_src_mux
(
    input  wire logic       clock,     // System clock
    input  wire logic       arst_n,    // Async reset, low
    input  wire logic [3:0] digit,     // Selection digit
    input  wire logic [3:0] trig_in,   // Synced triggers
    output logic            trig_out   // Chosen trigger
);
    // Codes above 3 are outside the range; only the low bits decode
    wire logic [1:0] code = digit[1:0];
    wire logic       sel  = trig_in[code];

    // Register the pick so the top output comes from a flop
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            trig_out <= 1'b0;
        else
            trig_out <= sel;
    end

    AST_MUX_PICK: assert property (
        @(posedge clock) disable iff (!arst_n)
        1 |=> trig_out == $past(trig_in[digit[1:0]]))
        else $error("latch source mux picked wrong input");
endmodule

/* lss_top.sv */
// Latch source select, homing speed gating and maintenance monitors
//
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
// Contract
// - Each step digit selects index pulse (0) or external latch a, b, c.
// - First word holds steps 1-4 low digit first, resets 0000, acts at once.
// - Second word holds steps 5-8 with the same four-value encoding.
// - Homing speed one is used only while its selector reads zero.
// - Homing speed two is used only while its selector reads zero.
// - Station address is reported read-only, in 40h-5Fh, zero by default; the code reports any 8-bit link value unclamped.
module lss_top
(
    input  wire logic        clock,          // System clock
    input  wire logic        arst_n,         // Async reset, low
    input  wire logic [7:0]  reg_addr,       // Register index
    input  wire logic [15:0] reg_wdata,      // Write data
    input  wire logic        reg_wr,         // Write strobe
    input  wire logic        reg_rd,         // Read strobe
    output logic      [15:0] reg_rdata,      // Read data, next cycle
    input  wire logic        index_pulse,    // Encoder index pin
    input  wire logic        external_latch_input_a, // Latch pin a
    input  wire logic        external_latch_input_b, // Latch pin b
    input  wire logic        external_latch_input_c, // Latch pin c
    input  wire logic        distribution_done_flag, // Motion stopped
    input  wire logic [7:0]  station_addr_in,  // From network link
    input  wire logic [7:0]  tx_bytes_in,      // From network link
    output logic      [7:0]  step_trigger,     // Per step trigger
    output logic      [31:0] homing_speed_one, // Gated speed one
    output logic      [31:0] homing_speed_two  // Gated speed two
);
    // Settings
    logic [15:0] latch_source_select_steps_1_4;
    logic [15:0] latch_source_select_steps_5_8;
    logic [15:0] station_address_monitor;
    logic [15:0] transmission_bytes_monitor;
    logic [31:0] homing_approach_speed_one;
    logic [31:0] homing_approach_speed_two;
    logic [15:0] homing_speed_one_selector;
    logic [15:0] homing_speed_two_selector;

    // Two-flop synchronisers for all pins
    logic [3:0]  trig_s1;
    logic [3:0]  trig_s2;
    logic [16:0] mon_s1;
    logic [16:0] mon_s2;
    wire  logic  done_sync = mon_s2[16];

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trig_s1 <= 4'h0;
            trig_s2 <= 4'h0;
            mon_s1  <= 17'h0_0000;
            mon_s2  <= 17'h0_0000;
        end
        else
        begin
            trig_s1 <= {external_latch_input_c, external_latch_input_b,
                        external_latch_input_a, index_pulse};
            trig_s2 <= trig_s1;
            mon_s1  <= {distribution_done_flag, tx_bytes_in,
                        station_addr_in};
            mon_s2  <= mon_s1;
        end
    end

    // Address decode
    wire logic hit_l14  = reg_addr == lss_pkg::OFS_LATCH_1_4;
    wire logic hit_l58  = reg_addr == lss_pkg::OFS_LATCH_5_8;
    wire logic hit_s1lo = reg_addr == lss_pkg::OFS_HOME_SPD1_LO;
    wire logic hit_s1hi = reg_addr == lss_pkg::OFS_HOME_SPD1_HI;
    wire logic hit_s2lo = reg_addr == lss_pkg::OFS_HOME_SPD2_LO;
    wire logic hit_s2hi = reg_addr == lss_pkg::OFS_HOME_SPD2_HI;
    wire logic hit_sel1 = reg_addr == lss_pkg::OFS_HOME_SEL1;
    wire logic hit_sel2 = reg_addr == lss_pkg::OFS_HOME_SEL2;

    // Writable settings; no range clamp, the host keeps values in range
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            latch_source_select_steps_1_4 <= lss_pkg::RST_LATCH;
            latch_source_select_steps_5_8 <= lss_pkg::RST_LATCH;
            homing_approach_speed_one     <= {2{lss_pkg::RST_HOME}};
            homing_approach_speed_two     <= {2{lss_pkg::RST_HOME}};
            homing_speed_one_selector     <= lss_pkg::RST_HOME;
            homing_speed_two_selector     <= lss_pkg::RST_HOME;
        end
        else if (reg_wr)
        begin
            if (hit_l14)
                latch_source_select_steps_1_4 <= reg_wdata;
            else if (hit_l58)
                latch_source_select_steps_5_8 <= reg_wdata;
            else if (hit_s1lo)
                homing_approach_speed_one[15:0] <= reg_wdata;
            else if (hit_s1hi)
                homing_approach_speed_one[31:16] <= reg_wdata;
            else if (hit_s2lo)
                homing_approach_speed_two[15:0] <= reg_wdata;
            else if (hit_s2hi)
                homing_approach_speed_two[31:16] <= reg_wdata;
            else if (hit_sel1)
                homing_speed_one_selector <= reg_wdata;
            else if (hit_sel2)
                homing_speed_two_selector <= reg_wdata;
        end
    end

    // Monitors follow the link; zero until the link reports a value
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            station_address_monitor    <= lss_pkg::RST_MONITOR;
            transmission_bytes_monitor <= lss_pkg::RST_MONITOR;
        end
        else
        begin
            station_address_monitor    <= {8'h00, mon_s2[7:0]};
            transmission_bytes_monitor <= {8'h00, mon_s2[15:8]};
        end
    end

    // Read mux; unmapped addresses read zero
    logic [15:0] next_rdata;
    always_comb
    begin
        next_rdata = 16'h0000;
        if (hit_l14)
            next_rdata = latch_source_select_steps_1_4;
        else if (hit_l58)
            next_rdata = latch_source_select_steps_5_8;
        else if (reg_addr == lss_pkg::OFS_STATION_ADDR)
            next_rdata = station_address_monitor;
        else if (reg_addr == lss_pkg::OFS_TX_BYTES)
            next_rdata = transmission_bytes_monitor;
        else if (hit_s1lo)
            next_rdata = homing_approach_speed_one[15:0];
        else if (hit_s1hi)
            next_rdata = homing_approach_speed_one[31:16];
        else if (hit_s2lo)
            next_rdata = homing_approach_speed_two[15:0];
        else if (hit_s2hi)
            next_rdata = homing_approach_speed_two[31:16];
        else if (hit_sel1)
            next_rdata = homing_speed_one_selector;
        else if (hit_sel2)
            next_rdata = homing_speed_two_selector;
        else if (reg_addr == lss_pkg::OFS_STATUS)
            next_rdata = 16'(done_sync) << lss_pkg::STAT_DONE_BIT;
    end

    // Read data live only in the cycle after the strobe
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 16'h0000;
    end

    // Homing speeds pass only while their selector is zero
    wire logic sel1_zero = homing_speed_one_selector == 16'h0000;
    wire logic sel2_zero = homing_speed_two_selector == 16'h0000;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            homing_speed_one <= 32'h0000_0000;
            homing_speed_two <= 32'h0000_0000;
        end
        else
        begin
            homing_speed_one <= sel1_zero ? homing_approach_speed_one
                                          : 32'h0000_0000;
            homing_speed_two <= sel2_zero ? homing_approach_speed_two
                                          : 32'h0000_0000;
        end
    end

    // Eight step muxes; low word digits feed steps 1-4, high word 5-8
    wire logic [31:0] digits = {latch_source_select_steps_5_8,
                                latch_source_select_steps_1_4};
    genvar g;
    generate
        for (g = 0; g < lss_pkg::STEPS; g++)
        begin : g_step
            lss_src_mux u_mux
            (
                .clock    (clock),
                .arst_n   (arst_n),
                .digit    (digits[g*4 +: 4]),
                .trig_in  (trig_s2),
                .trig_out (step_trigger[g])
            );
        end
    endgenerate

    // Rule checks on the flops that carry each rule
    AST_L14_WRITE: assert property (
        @(posedge clock) disable iff (!arst_n)
        reg_wr && hit_l14 |=> latch_source_select_steps_1_4
            == $past(reg_wdata))
        else $error("first latch word not written");
    AST_STEP5: assert property (
        @(posedge clock) disable iff (!arst_n)
        1 |=> ##1 step_trigger[4] == $past(trig_s2[
            latch_source_select_steps_5_8[1:0]]))
        else $error("step five uses wrong source");
    AST_STEP1: assert property (
        @(posedge clock) disable iff (!arst_n)
        1 |=> ##1 step_trigger[0] == $past(trig_s2[
            latch_source_select_steps_1_4[1:0]]))
        else $error("step one uses wrong source");
    AST_SPD1_GATE: assert property (
        @(posedge clock) disable iff (!arst_n)
        !sel1_zero |=> homing_speed_one == 32'h0000_0000)
        else $error("speed one passed with nonzero selector");
    AST_SPD1_PASS: assert property (
        @(posedge clock) disable iff (!arst_n)
        sel1_zero |=> homing_speed_one == $past(homing_approach_speed_one))
        else $error("speed one not passed with zero selector");
    AST_SPD2_GATE: assert property (
        @(posedge clock) disable iff (!arst_n)
        !sel2_zero |=> homing_speed_two == 32'h0000_0000)
        else $error("speed two passed with nonzero selector");
    AST_SPD2_PASS: assert property (
        @(posedge clock) disable iff (!arst_n)
        sel2_zero |=> homing_speed_two == $past(homing_approach_speed_two))
        else $error("speed two not passed with zero selector");
    AST_STATION: assert property (
        @(posedge clock) disable iff (!arst_n)
        reg_rd && reg_addr == lss_pkg::OFS_STATION_ADDR
            |=> reg_rdata == $past(station_address_monitor))
        else $error("station monitor read wrong");
    AST_RD_IDLE: assert property (
        @(posedge clock) disable iff (!arst_n)
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read");
    AST_MON_RO: assert property (
        @(posedge clock) disable iff (!arst_n)
        reg_wr && reg_addr == lss_pkg::OFS_STATION_ADDR
            |=> station_address_monitor == {8'h00, $past(mon_s2[7:0])})
        else $error("station monitor took a write");
endmodule

/* lss_host_model.sv */
// Host motion controller model driving the register port
`timescale 1ns/100ps
module lss_host_model
(
    input  wire logic        clock,                  // System clock
    output logic      [7:0]  reg_addr,               // Register index
    output logic      [15:0] reg_wdata,              // Write data
    output logic             reg_wr,                 // Write strobe
    output logic             reg_rd,                 // Read strobe
    output logic             distribution_done_flag  // Motion stopped
);
    // Idle port; motion held stopped so live settings may change
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        distribution_done_flag = 1'b1;
    end

    // One-cycle write; data inverted after release so no stale value lingers
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // One-cycle read; the bench watches the data in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask

    // Start or stop motion; settings are only written while stopped
    task automatic motion(input logic run);
        @(posedge clock);
        distribution_done_flag <= !run;
    endtask
endmodule

/* lss_top_test.sv */
// Self-checking bench for the latch source select block
`timescale 1ns/100ps
module lss_top_test;
    logic        clock;
    logic        arst_n;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        done;
    logic [3:0]  pins;
    logic [7:0]  sta;
    logic [7:0]  txb;
    logic [7:0]  step_trigger;
    logic [31:0] spd_one;
    logic [31:0] spd_two;
    logic [31:0] exp_q[$];
    logic        rd_q = 1'b0;
    int          n_errors;
    int          cmp_count;
    int          seed;

    // Host on the register port
    lss_host_model u_lss_host_model (.clock(clock), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .distribution_done_flag(done));

    lss_top u_lss_top (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .index_pulse(pins[0]),
        .external_latch_input_a(pins[1]), .external_latch_input_b(pins[2]),
        .external_latch_input_c(pins[3]), .distribution_done_flag(done),
        .station_addr_in(sta), .tx_bytes_in(txb),
        .step_trigger(step_trigger), .homing_speed_one(spd_one),
        .homing_speed_two(spd_two));

    // Free running 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Count a compare; one line per mismatch
    task automatic chk(input string       nm,
                       input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Step trigger compare, all eight steps at once
    task automatic chk_step(input logic [7:0] e);
        chk("step_trigger", {24'h0, e}, {24'h0, step_trigger});
    endtask

    // Gated homing speed compare for channel one or two
    task automatic chk_spd(input int ch, input logic [31:0] e);
        chk("homing_speed", e, (ch == 0) ? spd_one : spd_two);
    endtask

    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Note the expectation, then issue the read
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        u_lss_host_model.rd(a);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clock)
    begin
        if (rd_q === 1'b1)
            chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        rd_q <= reg_rd;
    end

    // Guard against a hung run
    initial
    begin
        #200000;
        n_errors++;
        end_of_test();
    end

    initial
    begin : main
        logic [15:0] w14;
        logic [15:0] w58;
        logic [31:0] spd;
        logic [15:0] sel;
        logic [7:0]  e;
        int          it;
        int          s;
        int          n;
        int          ch;
        seed = 32'hfacaf98d;
        n_errors = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        pins = 4'h0;
        sta = 8'h00;
        txb = 8'h00;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        // Reset values, status and an unmapped place
        rdc(lss_pkg::OFS_LATCH_1_4, 16'h0000);
        rdc(lss_pkg::OFS_LATCH_5_8, 16'h0000);
        rdc(lss_pkg::OFS_STATION_ADDR, 16'h0000);
        rdc(lss_pkg::OFS_STATUS, 16'h0001);
        rdc(8'h0F, 16'h0000);
        // Motion running clears the done bit; stopped again before writes
        u_lss_host_model.motion(1'b1);
        repeat (3) @(posedge clock);
        rdc(lss_pkg::OFS_STATUS, 16'h0000);
        u_lss_host_model.motion(1'b0);
        repeat (3) @(posedge clock);
        rdc(lss_pkg::OFS_STATUS, 16'h0001);
        // Monitor follows link, refuses writes; station kept in 40h-5Fh
        sta <= 8'h40 + 8'($random(seed) & 31);
        txb <= 8'($random(seed));
        u_lss_host_model.wr(lss_pkg::OFS_STATION_ADDR, 16'hFFFF);
        u_lss_host_model.wr(lss_pkg::OFS_TX_BYTES, 16'hFFFF);
        repeat (4) @(posedge clock);
        rdc(lss_pkg::OFS_STATION_ADDR, {8'h00, sta});
        rdc(lss_pkg::OFS_TX_BYTES, {8'h00, txb});
        // Every step under every source; first pass fixed, rest random
        for (it = 0; it < 6; it++)
        begin
            w14 = (it == 0) ? 16'h3210 : 16'($random(seed)) & 16'h3333;
            w58 = (it == 0) ? 16'h0123 : 16'($random(seed)) & 16'h3333;
            u_lss_host_model.wr(lss_pkg::OFS_LATCH_1_4, w14);
            u_lss_host_model.wr(lss_pkg::OFS_LATCH_5_8, w58);
            rdc(lss_pkg::OFS_LATCH_1_4, w14);
            rdc(lss_pkg::OFS_LATCH_5_8, w58);
            for (s = 0; s < 4; s++)
            begin
                @(posedge clock);
                pins <= 4'b0001 << s;
                repeat (4) @(posedge clock);
                #1;
                for (n = 0; n < 8; n++)
                    e[n] = ((({w58, w14} >> (4 * n)) & 32'h3) == s);
                chk_step(e);
            end
        end
        // Speed passes only while its selector is zero
        for (ch = 0; ch < 2; ch++)
            for (it = 0; it < 3; it++)
            begin
                spd = $random(seed);
                sel = (it == 1) ? (16'($random(seed)) | 16'h0001) : 16'h0000;
                u_lss_host_model.wr(
                    8'(lss_pkg::OFS_HOME_SPD1_LO + 2 * ch), spd[15:0]);
                u_lss_host_model.wr(
                    8'(lss_pkg::OFS_HOME_SPD1_HI + 2 * ch), spd[31:16]);
                u_lss_host_model.wr(8'(lss_pkg::OFS_HOME_SEL1 + ch), sel);
                repeat (3) @(posedge clock);
                #1;
                chk_spd(ch, (sel == 0) ? spd : 32'h0000_0000);
            end
        repeat (4) @(posedge clock);
        end_of_test();
    end
endmodule
